// [burst_sram_pkg.sv]
// shared constants, types and states of the burst memory access control
// assumes one clock domain; all users import the whole package
package burst_sram_pkg;

  localparam int LANES = 4;          // byte lanes in the widest organisation
  localparam int LANE_W = 8;         // data bits per lane
  localparam int ADDR_W = 8;         // word address bits, two lowest are the burst bits
  localparam int DEPTH = 256;        // words in the array
  localparam int FIFO_W = 36;        // width of one read word
  localparam int FIFO_DEPTH = 8;     // read words buffered toward the user

  // organisation strap codes
  typedef logic [1:0] org_t;
  localparam org_t ORG_X18 = 2'h0;   // two lanes, parity per lane
  localparam org_t ORG_X32 = 2'h1;   // four lanes, no parity
  localparam org_t ORG_X36 = 2'h2;   // four lanes, parity per lane

  // lane masks
  localparam logic [3:0] LANES_X18 = 4'h3;   // lanes 0 and 1
  localparam logic [3:0] LANES_WIDE = 4'hF;  // lanes 0 to 3
  localparam logic [3:0] LANES_NONE = 4'h0;  // nothing

  localparam logic [1:0] BURST_ZERO = 2'h0;  // first beat of a burst
  localparam logic [1:0] BURST_ONE = 2'h1;   // one step of the burst counter

  // one data word with its parity bits
  typedef struct packed {
    logic [LANES-1:0][LANE_W-1:0] data;  // lane 3 down to lane 0
    logic [LANES-1:0] parity;            // one parity bit per lane
  } bus_word_s;

  // access control pins, all active as named
  typedef struct packed {
    logic proc_addr_strobe_n;  // processor-side start
    logic ctrl_addr_strobe_n;  // controller-side start
    logic burst_advance_n;     // step the burst counter
    logic chip_sel_n;          // primary enable
    logic chip_sel_hi;         // secondary enable, high active
    logic chip_sel2_n;         // secondary enable, low active
  } ctrl_pins_s;

  // write control pins
  typedef struct packed {
    logic full_write_n;          // write every lane
    logic byte_write_master_n;   // lets the lane enables act
    logic [LANES-1:0] lane_write_n;  // lane3_write_n down to lane0_write_n
  } write_ctrl_s;

  // access states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,    // selected, no burst
    ST_READ = 3'b001,    // read burst running
    ST_WRITE = 3'b010,   // write burst running
    ST_PDOWN = 3'b011,   // deselected power-down
    ST_SNOOZE = 3'b100   // snooze, access inputs ignored
  } acc_state_e;

endpackage

// [burst_counter.sv]
// two-bit burst counter, linear or interleaved order
// assumes load and step never come together from the caller
module burst_counter
  import burst_sram_pkg::*;
(
  input wire logic clk,            // system clock
  input wire logic srst,           // synchronous reset
  input wire logic ce,             // clock enable
  input wire logic load,           // take a new start offset
  input wire logic step,           // advance one beat
  input wire logic linear,         // high: linear order
  input wire logic [1:0] base,     // start offset to load
  output logic [1:0] offset,       // offset of the current beat
  output logic [1:0] offset_step   // offset after one more step
);

  logic [1:0] base_q;      // loaded start offset
  logic [1:0] cnt;         // beats taken since load
  logic [1:0] next_base_q; // next start offset
  logic [1:0] next_cnt;    // next beat count
  logic [1:0] cnt_inc;     // count plus one, wraps by width

  ////////////////////////////////////////////////////////////////////////
  // order mapping: wrap at four in both orders
  always_comb begin
    cnt_inc = cnt + BURST_ONE;
    offset = linear ? base_q + cnt : base_q ^ cnt;
    offset_step = linear ? base_q + cnt_inc : base_q ^ cnt_inc;
  end

  ////////////////////////////////////////////////////////////////////////
  // next counter values
  always_comb begin
    next_base_q = base_q;
    next_cnt = cnt;
    if (load) begin
      next_base_q = base;
      next_cnt = BURST_ZERO;
    end else if (step) begin
      next_cnt = cnt_inc;
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      base_q <= BURST_ZERO;
      cnt <= BURST_ZERO;
    end else if (ce) begin
      base_q <= next_base_q;
      cnt <= next_cnt;
    end
  end

endmodule

// [word_fifo.sv]
// synchronous FIFO with valid/ready on both sides
// assumes depth is a power of two
module word_fifo #(
  parameter int WIDTH = 36,  // bits per word
  parameter int DEPTH = 8    // words held
) (
  input wire logic clk,                // system clock
  input wire logic srst,               // synchronous reset
  input wire logic ce,                 // clock enable
  input wire logic in_valid,           // word offered
  output logic in_ready,               // room for a word
  input wire logic [WIDTH-1:0] in_data,  // word in
  output logic out_valid,              // word available
  input wire logic out_ready,          // sink takes the word
  output logic [WIDTH-1:0] out_data    // oldest word
);

  localparam int PW = $clog2(DEPTH);  // pointer bits

  logic [WIDTH-1:0] mem [0:DEPTH-1];  // storage
  logic [PW:0] wr_ptr;                // write pointer with wrap bit
  logic [PW:0] rd_ptr;                // read pointer with wrap bit
  logic [PW:0] next_wr_ptr;           // next write pointer
  logic [PW:0] next_rd_ptr;           // next read pointer
  logic push;                         // word accepted
  logic pop;                          // word delivered

  ////////////////////////////////////////////////////////////////////////
  // flags and pointer steps
  always_comb begin
    in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {PW{1'b0}}};  // not full
    out_valid = wr_ptr != rd_ptr;                         // not empty
    out_data = mem[rd_ptr[PW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = wr_ptr + (PW + 1)'(push);
    next_rd_ptr = rd_ptr + (PW + 1)'(pop);
  end

  // registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage has no reset, contents only matter behind the pointers
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

endmodule

// [burst_sram_access.sv]
// access start, burst and byte-lane control of a pipelined burst memory
// assumes control pins come from logic on clk; only snooze is asynchronous
//
// Operation
// - processor strobe with enable loads new address
// - processor strobe start is always a read
// - processor strobe ignored while primary enable high
// - bad secondary enables on processor start: power-down
// - controller strobe start loads address, reads or writes
// - controller strobe, primary enable high: power-down
// - burst order select low linear, else interleaved
// - 18-bit organisation has lanes zero and one
// - 32/36-bit organisations have four lanes
// - 32-bit organisation stores and returns no parity
// - 18-bit organisation: parity bit per lane
// - 36-bit organisation: parity bit per lane
// - master enable low: low lane enables write lanes
// - full write low writes every lane
// - advance low steps, high holds the address
// - snooze keeps array, ignores access and write inputs; read_ready still drains read words
module burst_sram_access
  import burst_sram_pkg::*;
(
  input wire logic clk,                    // system clock, 100 MHz
  input wire logic srst,                   // synchronous reset
  input wire logic ce,                     // clock enable, freezes all state
  input wire logic snooze_req,             // asynchronous snooze request
  input wire logic burst_order_sel,        // strap: low linear, high interleaved
  input wire org_t org_sel,                // strap: organisation
  input wire ctrl_pins_s ctrl,             // strobes, advance, chip enables
  input wire write_ctrl_s wr,              // write controls
  input wire logic [ADDR_W-1:0] addr,      // external address
  input wire bus_word_s wdata,             // write data with parity
  output bus_word_s read_word,             // read data with parity
  output logic read_valid,                 // read word waiting
  input wire logic read_ready,             // user takes the read word
  output logic [ADDR_W-1:0] burst_addr,    // address of the last beat
  output logic power_down,                 // deselected power-down
  output logic snoozing,                   // in snooze
  output logic stalled                     // read buffer full, access frozen
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  bus_word_s mem [0:DEPTH-1];      // the array
  logic snz_meta;                  // snooze first sync stage
  logic snz_sync;                  // snooze second sync stage
  logic strap_done;                // straps captured
  org_t org_q;                     // captured organisation
  logic linear_q;                  // captured burst order
  logic next_strap_done;           // next capture flag
  org_t next_org_q;                // next organisation
  logic next_linear_q;             // next burst order
  acc_state_e state;               // access state
  acc_state_e next_state;          // next access state
  logic [ADDR_W-3:0] hi_addr;      // address bits above the burst bits
  logic [ADDR_W-3:0] next_hi_addr; // next upper address
  logic [ADDR_W-1:0] next_burst_addr;  // next reported address
  logic next_power_down;           // next power-down flag
  logic next_snoozing;             // next snooze flag
  logic next_stalled;              // next stall flag
  bus_word_s next_read_word;       // next output word
  logic next_read_valid;           // next output valid
  logic [3:0] lane_en;             // lanes present
  logic [3:0] par_en;              // parity bits present
  logic [3:0] wr_mask;             // lanes this cycle writes
  logic start_p;                   // processor start accepted
  logic start_c;                   // controller start accepted
  logic desel_c;                   // controller deselect
  logic cs_ok;                     // secondary enables select
  logic active;                    // burst running
  logic go;                        // logic may act this cycle
  logic step;                      // counter advances
  logic load;                      // counter loads
  logic do_write;                  // array write this cycle
  logic do_read;                   // read word pushed this cycle
  logic [1:0] offset;              // current burst offset
  logic [1:0] offset_step;         // burst offset after a step
  logic [ADDR_W-1:0] acc_addr;     // address of this cycle's beat
  bus_word_s rd_raw;               // array word, lanes masked
  bus_word_s f_out;                // buffer output word
  logic f_in_ready;                // buffer has room
  logic f_out_valid;               // buffer has a word
  logic f_out_ready;               // output register can take a word

  ////////////////////////////////////////////////////////////////////////
  // snooze synchroniser, first stage read only by the second
  always_ff @(posedge clk) begin
    if (srst) begin
      snz_meta <= 1'b0;
      snz_sync <= 1'b0;
    end else if (ce) begin
      snz_meta <= snooze_req;
      snz_sync <= snz_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture once after reset release; later changes are ignored,
  // which is safe only because the order select never moves in use
  always_comb begin
    next_strap_done = 1'b1;
    next_org_q = strap_done ? org_q : org_sel;
    next_linear_q = strap_done ? linear_q : !burst_order_sel;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strap_done <= 1'b0;
      org_q <= ORG_X36;
      linear_q <= 1'b0;
    end else if (ce) begin
      strap_done <= next_strap_done;
      org_q <= next_org_q;
      linear_q <= next_linear_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lane map and write decode
  always_comb begin
    lane_en = (org_q == ORG_X18) ? LANES_X18 : LANES_WIDE;
    par_en = (org_q == ORG_X32) ? LANES_NONE : lane_en;
    if (!wr.full_write_n) begin
      wr_mask = lane_en;
    end else if (!wr.byte_write_master_n) begin
      wr_mask = ~wr.lane_write_n & lane_en;
    end else begin
      wr_mask = LANES_NONE;                                 // read cycle
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access decode; a full read buffer freezes all access logic, the read side still drains, so no word is lost
  always_comb begin
    go = ce && f_in_ready && !snz_sync;
    cs_ok = ctrl.chip_sel_hi && !ctrl.chip_sel2_n;
    start_p = !ctrl.proc_addr_strobe_n && !ctrl.chip_sel_n;
    start_c = ctrl.proc_addr_strobe_n && !ctrl.ctrl_addr_strobe_n
      && !ctrl.chip_sel_n;
    desel_c = !ctrl.ctrl_addr_strobe_n && ctrl.chip_sel_n;
    active = (state == ST_READ) || (state == ST_WRITE);
    load = go && (start_p || start_c) && cs_ok;
    step = go && active && !start_p && !start_c && !desel_c
      && !ctrl.burst_advance_n;
    acc_addr = (start_p || start_c) ? addr : {hi_addr, offset};
    do_write = go && (wr_mask != LANES_NONE) && ((start_c && cs_ok)
      || (active && !start_p && !start_c && !desel_c));
    do_read = go && ((start_p && cs_ok)
      || (start_c && cs_ok && wr_mask == LANES_NONE)
      || (state == ST_READ && step));
  end

  // read word picks the stepped beat on an advance, the loaded one on a start
  always_comb begin
    rd_raw = (state == ST_READ && step) ? mem[{hi_addr, offset_step}] : mem[acc_addr];
    for (int i = 0; i < LANES; i++) begin
      if (!lane_en[i]) begin
        rd_raw.data[i] = '0;
      end
      if (!par_en[i]) begin
        rd_raw.parity[i] = 1'b0;
      end
    end
  end

  burst_counter u_counter (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .load(load),
    .step(step),
    .linear(linear_q),
    .base(addr[1:0]),
    .offset(offset),
    .offset_step(offset_step)
  );

  ////////////////////////////////////////////////////////////////////////
  // array write, per lane with its parity bit
  always_ff @(posedge clk) begin
    if (do_write) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_mask[i]) begin
          mem[acc_addr].data[i] <= wdata.data[i];
          mem[acc_addr].parity[i] <= par_en[i] && wdata.parity[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // access state, address and status next values
  always_comb begin
    next_state = state;
    next_hi_addr = hi_addr;
    next_burst_addr = burst_addr;
    if (snz_sync) begin
      next_state = ST_SNOOZE;
    end else if (!go) begin
      next_state = state;                                               // frozen
    end else if (start_p) begin
      next_state = cs_ok ? ST_READ : ST_PDOWN;
    end else if (start_c) begin
      if (!cs_ok) begin
        next_state = ST_PDOWN;
      end else begin
        next_state = (wr_mask != LANES_NONE) ? ST_WRITE : ST_READ;
      end
    end else if (desel_c) begin
      next_state = ST_PDOWN;
    end else if (state == ST_SNOOZE) begin
      next_state = ST_IDLE;                                             // wake up
    end else if (active && wr_mask != LANES_NONE) begin
      next_state = ST_WRITE;
    end
    if (load) begin
      next_hi_addr = addr[ADDR_W-1:2];
    end
    if (load || step || do_write) begin
      next_burst_addr = (state == ST_READ && step) ? {hi_addr, offset_step} : acc_addr;
    end
    next_power_down = next_state == ST_PDOWN;
    next_snoozing = next_state == ST_SNOOZE;
    next_stalled = ce ? !f_in_ready : stalled;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      hi_addr <= '0;
      burst_addr <= '0;
      power_down <= 1'b0;
      snoozing <= 1'b0;
      stalled <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      hi_addr <= next_hi_addr;
      burst_addr <= next_burst_addr;
      power_down <= next_power_down;
      snoozing <= next_snoozing;
      stalled <= next_stalled;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read buffer and output register
  word_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .in_valid(do_read),
    .in_ready(f_in_ready),
    .in_data(rd_raw),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );

  always_comb begin
    f_out_ready = !read_valid || read_ready;
    next_read_valid = read_valid;
    next_read_word = read_word;
    if (f_out_ready) begin
      next_read_valid = f_out_valid;
      next_read_word = f_out_valid ? f_out : read_word;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_valid <= 1'b0;
      read_word <= '0;
    end else if (ce) begin
      read_valid <= next_read_valid;
      read_word <= next_read_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence seq_go;
    ce && f_in_ready && !snz_sync;
  endsequence

  sequence seq_proc_start;
    seq_go ##0 (!ctrl.proc_addr_strobe_n && !ctrl.chip_sel_n);
  endsequence

  sequence seq_ctrl_start;
    seq_go ##0 (ctrl.proc_addr_strobe_n && !ctrl.ctrl_addr_strobe_n && !ctrl.chip_sel_n);
  endsequence

  AST_PROC_READ: assert property (seq_proc_start ##0 cs_ok |=> state == ST_READ)
    else $error("processor start did not read");
  AST_PROC_LOAD: assert property (seq_proc_start ##0 cs_ok |=> hi_addr == $past(addr[ADDR_W-1:2]))
    else $error("processor start did not load address");
  AST_PROC_IGNORED: assert property (seq_go ##0 (ctrl.chip_sel_n
    && ctrl.ctrl_addr_strobe_n && state == ST_IDLE) |=> state == ST_IDLE)
    else $error("processor strobe acted while disabled");
  AST_PROC_PDOWN: assert property (seq_proc_start ##0 !cs_ok |=> power_down)
    else $error("no power-down on bad secondary enables");
  AST_CTRL_WRITE: assert property (seq_ctrl_start ##0 (cs_ok && wr_mask != LANES_NONE)
    |-> do_write ##1 state == ST_WRITE)
    else $error("controller write start failed");
  AST_CTRL_PDOWN: assert property (seq_go ##0 (ctrl.proc_addr_strobe_n
    && !ctrl.ctrl_addr_strobe_n && ctrl.chip_sel_n) |=> power_down)
    else $error("controller deselect missed");
  AST_LINEAR_STEP: assert property (step && linear_q |=> offset == $past(offset) + BURST_ONE)
    else $error("linear step wrong");
  AST_HOLD: assert property (ce && active && !step && !load |=> offset == $past(offset))
    else $error("burst address moved without advance");
  AST_X32_NO_PARITY: assert property (read_valid && org_q == ORG_X32 |-> read_word.parity == 4'h0)
    else $error("parity returned in 32-bit organisation");
  AST_X18_LANES: assert property (read_valid && org_q == ORG_X18
    |-> read_word.data[3:2] == '0 && read_word.parity[3:2] == 2'h0)
    else $error("upper lanes active in 18-bit organisation");
  AST_FULL_WRITE: assert property (!wr.full_write_n |-> wr_mask == lane_en)
    else $error("full write did not cover every lane");
  AST_SNOOZE: assert property (ce && snz_sync |-> !do_write && !do_read ##1 snoozing)
    else $error("snooze not honoured");

endmodule

// [far_side.sv]
// far-side model: bus master holding the straps and sinking read words
// assumes the bench steers stalls through hold_off
module far_side
  import burst_sram_pkg::*;
#(
  parameter logic ORDER = 1'b0,  // burst order strap level
  parameter org_t ORG = ORG_X36  // organisation strap
) (
  input wire logic hold_off,      // stall the read stream
  output logic burst_order_sel,   // strap to the block
  output org_t org_sel,           // strap to the block
  output logic read_ready         // takes read words
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  // straps are wired, so they cannot move mid-run
  assign burst_order_sel = ORDER;
  assign org_sel = ORG;
  // sink takes every word unless told to stall
  assign read_ready = !hold_off;
endmodule

// [tb.sv]
// self-checking bench for the burst memory access control
// assumes far-side models hold the straps fixed: x36 linear, x18 interleaved, x32 linear
module tb
  import burst_sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam ctrl_pins_s C_IDLE = 6'h3A, C_PROC = 6'h1A, C_CTRL = 6'h2A, C_ADV = 6'h32;
  localparam ctrl_pins_s C_PIGN = 6'h1E, C_PSEC = 6'h18, C_CDES = 6'h2E, C_BOTH = 6'h0A;
  localparam write_ctrl_s W_NONE = 6'h3F, W_FULL = 6'h1F, W_LANE0 = 6'h2E;
  logic clk, srst, snooze_req, stall, read_ready, read_valid, power_down, snoozing, stalled;
  logic burst_order_sel;
  org_t org_sel;
  ctrl_pins_s ctrl;
  write_ctrl_s wr;
  logic [ADDR_W-1:0] addr, burst_addr;
  bus_word_s wdata, read_word, ex;
  int n_mismatch, num_checks, i;
  burst_sram_access burst_sram_access_inst (.clk(clk), .srst(srst), .ce(1'b1),
    .snooze_req(snooze_req), .burst_order_sel(burst_order_sel), .org_sel(org_sel),
    .ctrl(ctrl), .wr(wr), .addr(addr), .wdata(wdata), .read_word(read_word),
    .read_valid(read_valid), .read_ready(read_ready), .burst_addr(burst_addr),
    .power_down(power_down), .snoozing(snoozing), .stalled(stalled));
  far_side far_side_inst (.hold_off(stall), .burst_order_sel(burst_order_sel),
    .org_sel(org_sel), .read_ready(read_ready));
  // two more copies on the same pins: x18 interleaved and x32 linear
  for (genvar k = 1; k < 3; k++) begin : alt
    logic order, ready, valid;  // strap and sink of this copy
    org_t org;  // organisation strap of this copy
    bus_word_s word;  // read word of this copy
    burst_sram_access burst_sram_access_inst (.clk(clk), .srst(srst), .ce(1'b1),
      .snooze_req(snooze_req), .burst_order_sel(order), .org_sel(org), .ctrl(ctrl), .wr(wr),
      .addr(addr), .wdata(wdata), .read_word(word), .read_valid(valid),
      .read_ready(ready), .burst_addr(), .power_down(), .snoozing(), .stalled());
    far_side #(.ORDER(k == 1), .ORG(k == 1 ? ORG_X18 : ORG_X32)) far_side_inst (
      .hold_off(stall), .burst_order_sel(order), .org_sel(org), .read_ready(ready));
  end
  ////////////////////////////////////////////////////////////////
  // distinct pattern per address, parity included
  function automatic bus_word_s word_of(input logic [7:0] a);
    return {a, ~a, a + 8'h01, a ^ 8'h5A, a[3:0]};
  endfunction
  // what a narrower organisation returns: absent lanes and parity read zero
  function automatic bus_word_s narrow(input bus_word_s w, input org_t o);
    if (o == ORG_X18) begin
      w.data[3:2] = '0;
      w.parity[3:2] = 2'h0;
    end
    if (o == ORG_X32) begin
      w.parity = 4'h0;
    end
    return w;
  endfunction
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one access cycle on the pins
  task automatic step(input ctrl_pins_s c, input write_ctrl_s w, input logic [7:0] a,
                      input bus_word_s d);
    @(posedge clk);
    ctrl <= c;
    wr <= w;
    addr <= a;
    wdata <= d;
  endtask
  // back to idle pins, then let n edges pass
  task automatic rest(input int k);
    step(C_IDLE, W_NONE, 8'h00, '0);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // bounded wait for a taken word on the x36 copy, the other copies checked then; a missing word ends the run
  // e is the linear expectation, ei the interleaved one
  task automatic pop(input bus_word_s e, input bus_word_s ei, input int lim);
    int k;
    bit got;
    k = 0;
    got = 0;
    while (!got && k < lim) begin
      @(posedge clk);
      k++;
      if (read_valid === 1'b1 && read_ready === 1'b1) got = 1;
    end
    if (!got) begin
      n_mismatch++;
      complete_run();
    end else begin
      chk("read_word", read_word, e);
      chk("alt_valid", {alt[1].valid, alt[2].valid}, 2'h3);
      chk("x18_word", alt[1].word, narrow(ei, ORG_X18));
      chk("x32_word", alt[2].word, narrow(e, ORG_X32));
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    srst = 1;
    snooze_req = 0;
    stall = 0;
    ctrl = C_IDLE;
    wr = W_NONE;
    addr = 0;
    wdata = '0;
    repeat (3) @(posedge clk);
    srst <= 0;
    rest(1);
    chk("flags", {read_valid, power_down, snoozing, stalled}, 0);
    // back-to-back controller writes
    for (i = 0; i < 4; i++) step(C_CTRL, W_FULL, 8'(8'h10 + i), word_of(8'(8'h10 + i)));
    rest(2);
    chk("burst_addr", burst_addr, 8'h13);
    // controller start with no write enables reads
    step(C_CTRL, W_NONE, 8'h13, '0);
    rest(0);
    pop(word_of(8'h13), word_of(8'h13), 40);
    // read burst with the sink stalled until the buffer refuses
    // odd start offset so linear and interleaved orders differ
    stall <= 1;
    step(C_PROC, W_NONE, 8'h11, '0);
    step(C_IDLE, W_NONE, 8'h00, '0);
    for (i = 0; i < 12; i++) step(C_ADV, W_NONE, 8'h00, '0);
    rest(2);
    chk("stalled", stalled, 1'b1);
    stall <= 0;
    // buffer depth plus the output register, then nothing more
    for (i = 0; i < FIFO_DEPTH + 1; i++) begin
      pop(word_of(8'(8'h10 + (1 + i) % 4)), word_of(8'(8'h10 + (1 ^ (i % 4)))), 12);
    end
    rest(2);
    chk("drained", read_valid, 1'b0);
    chk("stalled", stalled, 1'b0);
    // one lane through the master enable
    step(C_CTRL, W_FULL, 8'h20, word_of(8'h20));
    step(C_CTRL, W_LANE0, 8'h20, word_of(8'h55));
    step(C_PROC, W_NONE, 8'h20, '0);
    rest(0);
    ex = word_of(8'h20);
    ex.data[0] = word_of(8'h55).data[0];
    ex.parity[0] = word_of(8'h55).parity[0];
    pop(ex, ex, 40);
    // processor strobe with primary enable high does nothing
    step(C_PIGN, W_NONE, 8'h33, '0);
    rest(3);
    chk("burst_addr", burst_addr, 8'h20);
    chk("power_down", {power_down, read_valid}, 2'h0);
    step(C_PSEC, W_NONE, 8'h10, '0);
    rest(3);
    chk("power_down", {power_down, read_valid}, 2'h2);
    step(C_PROC, W_FULL, 8'h10, word_of(8'h77));
    rest(0);
    pop(word_of(8'h10), word_of(8'h10), 40);
    chk("power_down", power_down, 1'b0);
    step(C_CDES, W_FULL, 8'h11, word_of(8'h77));
    rest(3);
    chk("power_down", power_down, 1'b1);
    step(C_BOTH, W_FULL, 8'h20, word_of(8'h77));
    rest(0);
    pop(ex, ex, 40);
    // snooze ignores a write request
    @(posedge clk);
    snooze_req <= 1;
    rest(4);
    chk("snoozing", snoozing, 1'b1);
    step(C_CTRL, W_FULL, 8'h20, word_of(8'h99));
    rest(1);
    @(posedge clk);
    snooze_req <= 0;
    rest(4);
    chk("snoozing", snoozing, 1'b0);
    step(C_PROC, W_NONE, 8'h20, '0);
    rest(0);
    pop(ex, ex, 40);
    complete_run();
  end
endmodule
